/* common/etps_map.svh */
`ifndef ETPS_MAP_SVH
`define ETPS_MAP_SVH

// catastrophic error pulse length in base clock cycles
`define ETPS_MCE_PULSE_CYCLES 16
// regulator link half period of its serial clock, in base clock cycles
`define ETPS_VR_HALF_CYCLES   4
// regulator link frame sizes
`define ETPS_VR_CMD_BITS      8
`define ETPS_VR_RSP_BITS      8

// positions in the synchroniser vector
`define ETPS_SI_HOT           0
`define ETPS_SI_CORE_GOOD     1
`define ETPS_SI_STBY_GOOD     2
`define ETPS_SI_VR_DATA       3
`define ETPS_SI_VR_ALERT      4
`define ETPS_SI_POWER_STATUS_SIDEBAND_IN       5
`define ETPS_SI_EXT_THERM     6
`define ETPS_SI_MGR_LINE      7
`define ETPS_SI_WIDTH         8
// synchroniser reset value: every line at its idle level (supply goods and hub status low)
`define ETPS_SI_IDLE          8'hD9

`endif

/* common/etps_pkg.sv */
`include "etps_map.svh"
`default_nettype none

package etps_pkg;

   // one open-drain or two-way pin as seen by the logic
   typedef struct packed
   {
      logic out;
      logic oe;
   } etps_od_t;

   // regulator link request from the user side
   typedef struct packed
   {
      logic                          start;
      logic [`ETPS_VR_CMD_BITS-1:0] cmd;
   } etps_vr_req_t;

   // regulator link answer to the user side
   typedef struct packed
   {
      logic                          done;
      logic [`ETPS_VR_RSP_BITS-1:0] rsp;
   } etps_vr_rsp_t;

   typedef enum logic [1:0] {VR_IDLE, VR_SEND, VR_RECV, VR_DONE} etps_vr_state_t;

endpackage

`default_nettype wire

/* logic/etps_signalling.sv */
`timescale 1ns/1ps
`default_nettype none
`include "etps_map.svh"

module etps_signalling #(
   parameter int MCE_CYCLES = `ETPS_MCE_PULSE_CYCLES,
   parameter int VR_HALF    = `ETPS_VR_HALF_CYCLES
)(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   // internal fault and reset events
   input  wire logic                  machineCheckFault,
   input  wire logic                  internalFault,
   input  wire logic                  warmReset,
   input  wire logic                  coldReset,
   // internal thermal sensing
   input  wire logic                  tempMaxSafe,
   input  wire logic                  tccEnable,
   input  wire logic                  junctionOverTrip,
   // error and thermal pins
   output etps_pkg::etps_od_t         catastrophicErrorN,
   input  wire logic                  overtempAlertNIn,
   output etps_pkg::etps_od_t         overtempAlertN,
   output etps_pkg::etps_od_t         thermalShutdownN,
   // power good inputs
   input  wire logic                  coreSupplyGood,
   input  wire logic                  standbySupplyGood,
   // regulator serial link pins
   output etps_pkg::etps_od_t         regulatorSerialClock,
   input  wire logic                  regulatorSerialDataIn,
   output etps_pkg::etps_od_t         regulatorSerialData,
   input  wire logic                  regulatorAlertN,
   // companion hub sidebands
   input  wire logic                  powerStatusSidebandIn,
   output logic                       powerStatusSidebandOut,
   input  wire logic                  externalThermalSensorN,
   // manager single-wire sideband
   input  wire logic                  managerLineIn,
   output etps_pkg::etps_od_t         managerLine,
   input  wire logic                  managerDriveLow,
   output logic                       managerLineLevel,
   // user side
   input  wire etps_pkg::etps_vr_req_t vrReq,
   output etps_pkg::etps_vr_rsp_t     vrRsp,
   output logic                       vrBusy,
   output logic                       vrAlert,
   output logic                       thermalControlActive,
   output logic                       openLoopThermalMgmt,
   output logic                       closedLoopThermalMgmt,
   output logic                       haltExecution,
   output logic                       operationEnable
);

   localparam int CW = $clog2(MCE_CYCLES + 1);
   localparam int DW = $clog2(VR_HALF + 1);
   localparam int BW = $clog2(`ETPS_VR_CMD_BITS + `ETPS_VR_RSP_BITS + 1);
   localparam int cVrWait = 1000;

   //------------------------------------------------------------
   // input synchronisers
   //------------------------------------------------------------
   logic [`ETPS_SI_WIDTH-1:0] syncA;
   logic [`ETPS_SI_WIDTH-1:0] syncB;
   logic [`ETPS_SI_WIDTH-1:0] rawIn;

   // pins gathered into one vector
   always_comb
   begin
      rawIn                     = '0;
      rawIn[`ETPS_SI_HOT]       = overtempAlertNIn;
      rawIn[`ETPS_SI_CORE_GOOD] = coreSupplyGood;
      rawIn[`ETPS_SI_STBY_GOOD] = standbySupplyGood;
      rawIn[`ETPS_SI_VR_DATA]   = regulatorSerialDataIn;
      rawIn[`ETPS_SI_VR_ALERT]  = regulatorAlertN;
      rawIn[`ETPS_SI_POWER_STATUS_SIDEBAND_IN]   = powerStatusSidebandIn;
      rawIn[`ETPS_SI_EXT_THERM] = externalThermalSensorN;
      rawIn[`ETPS_SI_MGR_LINE]  = managerLineIn;
   end

   // two flops; each line resets to its idle level, so no false event or supply good
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         syncA <= `ETPS_SI_IDLE;
         syncB <= `ETPS_SI_IDLE;
      end
      else
      begin
         syncA <= rawIn;
         syncB <= syncA;
      end
   end

   //------------------------------------------------------------
   // catastrophic error
   //------------------------------------------------------------
   logic [CW-1:0] catCnt;
   logic [CW-1:0] next_catCnt;
   logic          catLatched;
   logic          next_catLatched;

   // pulse counter and latched fault
   always_comb
   begin
      next_catCnt = catCnt;
      if (machineCheckFault)
         next_catCnt = CW'(MCE_CYCLES);
      else if (catCnt != '0)
         next_catCnt = catCnt - CW'(1);
      // set wins over the reset events
      next_catLatched = internalFault | (catLatched & ~(warmReset | coldReset));
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         catCnt     <= '0;
         catLatched <= 1'b0;
      end
      else
      begin
         catCnt     <= next_catCnt;
         catLatched <= next_catLatched;
      end
   end

   //------------------------------------------------------------
   // thermal control, trip and sidebands
   //------------------------------------------------------------
   logic tripLatched;
   logic next_tripLatched;
   logic hotDrive;
   logic next_hotDrive;
   logic forcedHot;
   logic [1:0] hotEcho;
   logic [1:0] next_hotEcho;
   logic extEvent;
   logic next_pmDown;
   logic next_tcc;

   // own drive echoes through the synchroniser for two clocks after release; mask it
   assign forcedHot = ~syncB[`ETPS_SI_HOT] & ~hotDrive & ~(|hotEcho);
   assign extEvent  = ~syncB[`ETPS_SI_EXT_THERM];

   // next thermal state
   always_comb
   begin
      next_tripLatched = junctionOverTrip | tripLatched;
      next_hotDrive    = tempMaxSafe;
      next_hotEcho     = {hotEcho[0], hotDrive};
      next_tcc         = (tccEnable & tempMaxSafe) | forcedHot;
      next_pmDown      = extEvent;
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tripLatched            <= 1'b0;
         hotDrive               <= 1'b0;
         hotEcho                <= '0;
         thermalControlActive   <= 1'b0;
         powerStatusSidebandOut <= 1'b0;
      end
      else
      begin
         tripLatched            <= next_tripLatched;
         hotDrive               <= next_hotDrive;
         hotEcho                <= next_hotEcho;
         thermalControlActive   <= next_tcc;
         powerStatusSidebandOut <= next_pmDown;
      end
   end

   // pins and status; open-drain drives low only
   assign catastrophicErrorN.oe  = (catCnt != '0) | catLatched;
   assign catastrophicErrorN.out = 1'b0;
   assign overtempAlertN.oe      = hotDrive;
   assign overtempAlertN.out     = 1'b0;
   assign thermalShutdownN.oe    = tripLatched;
   assign thermalShutdownN.out   = 1'b0;
   assign haltExecution          = tripLatched;
   assign operationEnable        = syncB[`ETPS_SI_CORE_GOOD] & syncB[`ETPS_SI_STBY_GOOD]
                                   & ~tripLatched;
   assign openLoopThermalMgmt    = thermalControlActive | powerStatusSidebandOut;
   assign closedLoopThermalMgmt  = thermalControlActive | powerStatusSidebandOut
                                   | syncB[`ETPS_SI_POWER_STATUS_SIDEBAND_IN];
   assign managerLine.oe         = managerDriveLow;
   assign managerLine.out        = 1'b0;
   assign managerLineLevel       = syncB[`ETPS_SI_MGR_LINE];
   assign vrAlert                = ~syncB[`ETPS_SI_VR_ALERT];

   //------------------------------------------------------------
   // regulator serial link
   //------------------------------------------------------------
   etps_pkg::etps_vr_state_t vrState;
   etps_pkg::etps_vr_state_t next_vrState;
   logic [DW-1:0] divCnt;
   logic [DW-1:0] next_divCnt;
   logic [BW-1:0] bitCnt;
   logic [BW-1:0] next_bitCnt;
   logic [`ETPS_VR_CMD_BITS-1:0] shiftOut;
   logic [`ETPS_VR_CMD_BITS-1:0] next_shiftOut;
   logic [`ETPS_VR_RSP_BITS-1:0] shiftIn;
   logic [`ETPS_VR_RSP_BITS-1:0] next_shiftIn;
   logic sclk;
   logic next_sclk;
   logic outBit;
   logic next_outBit;
   logic tick;

   assign tick = (divCnt == DW'(VR_HALF - 1));

   // frame sequencer: data set on falling, sampled on rising clock
   always_comb
   begin
      next_vrState  = vrState;
      next_divCnt   = '0;
      next_bitCnt   = bitCnt;
      next_shiftOut = shiftOut;
      next_shiftIn  = shiftIn;
      next_sclk     = sclk;
      next_outBit   = outBit;
      case (vrState)
         etps_pkg::VR_IDLE:
         begin
            next_sclk   = 1'b1;
            next_outBit = 1'b1;
            if (vrReq.start)
            begin
               next_shiftOut = vrReq.cmd;
               next_bitCnt   = BW'(`ETPS_VR_CMD_BITS);
               next_vrState  = etps_pkg::VR_SEND;
            end
         end
         etps_pkg::VR_SEND:
         begin
            next_divCnt = tick ? '0 : divCnt + DW'(1);
            if (tick)
            begin
               next_sclk = ~sclk;
               if (sclk)
                  next_outBit = shiftOut[`ETPS_VR_CMD_BITS-1];
               else
               begin
                  next_shiftOut = shiftOut << 1;
                  next_bitCnt   = bitCnt - BW'(1);
                  if (bitCnt == BW'(1))
                  begin
                     next_bitCnt  = BW'(`ETPS_VR_RSP_BITS);
                     next_vrState = etps_pkg::VR_RECV;
                  end
               end
            end
         end
         etps_pkg::VR_RECV:
         begin
            next_divCnt = tick ? '0 : divCnt + DW'(1);
            if (tick)
            begin
               next_sclk = ~sclk;
               if (sclk)
                  next_outBit = 1'b1; // release line for the answer
               else
               begin
                  next_shiftIn = {shiftIn[`ETPS_VR_RSP_BITS-2:0], syncB[`ETPS_SI_VR_DATA]};
                  next_bitCnt  = bitCnt - BW'(1);
                  if (bitCnt == BW'(1))
                     next_vrState = etps_pkg::VR_DONE;
               end
            end
         end
         default:
            next_vrState = etps_pkg::VR_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         vrState  <= etps_pkg::VR_IDLE;
         divCnt   <= '0;
         bitCnt   <= '0;
         shiftOut <= '0;
         shiftIn  <= '0;
         sclk     <= 1'b1;
         outBit   <= 1'b1;
      end
      else
      begin
         vrState  <= next_vrState;
         divCnt   <= next_divCnt;
         bitCnt   <= next_bitCnt;
         shiftOut <= next_shiftOut;
         shiftIn  <= next_shiftIn;
         sclk     <= next_sclk;
         outBit   <= next_outBit;
      end
   end

   assign regulatorSerialClock.oe  = ~sclk;
   assign regulatorSerialClock.out = 1'b0;
   assign regulatorSerialData.oe   = ~outBit;
   assign regulatorSerialData.out  = 1'b0;
   assign vrRsp.done               = (vrState == etps_pkg::VR_DONE);
   assign vrRsp.rsp                = shiftIn;
   assign vrBusy                   = (vrState != etps_pkg::VR_IDLE);

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_mce_load_count: assert property (machineCheckFault |=> catCnt == CW'(MCE_CYCLES))
      else $error("pulse counter not loaded");
   a_mce_pulse_end: assert property ((catCnt == CW'(1)) && !machineCheckFault && !catLatched
      && !internalFault |=> !catastrophicErrorN.oe)
      else $error("catastrophic pulse too long");
   a_internal_fault_hold_low: assert property (catLatched && !warmReset && !coldReset
      |=> catastrophicErrorN.oe
      ##1 (catastrophicErrorN.oe || $past(warmReset) || $past(coldReset)))
      else $error("latched error dropped early");
   a_internal_fault_reset_clear: assert property ((warmReset || coldReset) && !internalFault
      |=> !catLatched)
      else $error("latched error not cleared");
   a_cat_only_cause: assert property ($rose(catastrophicErrorN.oe)
      |-> $past(machineCheckFault) || $past(internalFault))
      else $error("catastrophic error without cause");
   a_hot_pin_drive: assert property (tempMaxSafe |=> overtempAlertN.oe)
      else $error("overtemp alert not driven");
   a_tcc_forced_on: assert property (forcedHot |=> thermalControlActive)
      else $error("forced hot ignored");
   a_trip_halt_sticky: assert property (junctionOverTrip |=> haltExecution
      && thermalShutdownN.oe ##1 haltExecution)
      else $error("thermal trip not held");
   a_vr_frame_ends: assert property (vrReq.start && !vrBusy |-> ##[1:cVrWait] vrRsp.done)
      else $error("regulator frame hung");
   a_power_status_sideband_out_wake: assert property (extEvent |=> powerStatusSidebandOut)
      else $error("wake event not signalled");
   a_od_never_high: assert property (!catastrophicErrorN.out && !thermalShutdownN.out
      && !regulatorSerialData.out)
      else $error("open drain driven high");

   c_mce_pulse: cover property (machineCheckFault ##1 catastrophicErrorN.oe [*8]);
   c_internal_fault_cleared: cover property (catLatched ##1 warmReset ##1 !catLatched);
   c_vr_frame: cover property (vrReq.start ##[1:cVrWait] vrRsp.done);
   c_trip: cover property ($rose(haltExecution));

endmodule

`default_nettype wire

/* tb/etps_regulator_model.sv */
`timescale 1ns/1ps
`default_nettype none

module etps_regulator_model (
   // reset
   input  wire logic reset_n,
   // board lines
   input  wire logic sclkLine,
   input  wire logic dataLine,
   input  wire logic raiseAlert,
   // drives toward the board
   output logic      dataDriveLow,
   output logic      alertN
);
   int         bitCnt;
   logic [7:0] cmdShift;
   logic [7:0] rspShift;

   // alert wire, low while the bench asks for it
   assign alertN = ~raiseAlert;

   // one process for both clock edges, so the data drive has a single writer
   always @(posedge sclkLine or negedge sclkLine or negedge reset_n)
   begin
      if (!reset_n)
      begin
         bitCnt = 0;
         dataDriveLow = 1'b0;
      end
      else if (sclkLine)
      begin
         // command bits taken on each rising clock, answer built after eight
         if (bitCnt < 8)
            cmdShift = {cmdShift[6:0], dataLine};
         bitCnt = bitCnt + 1;
         if (bitCnt == 8)
            rspShift = {cmdShift[3:0], cmdShift[7:4]} ^ 8'h3C;
         if (bitCnt == 16)
         begin
            bitCnt = 0;
            dataDriveLow = 1'b0; // released, pull-up takes over
         end
      end
      else if (bitCnt >= 8 && bitCnt < 16)
         dataDriveLow = ~rspShift[15 - bitCnt]; // answer msb first
   end
endmodule

`default_nettype wire

/* tb/error_thermal_power_signalling_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module error_thermal_power_signalling_tb;
   logic clock, reset_n, machineCheckFault, internalFault, warmReset, coldReset;
   logic tempMaxSafe, tccEnable, junctionOverTrip, coreSupplyGood, standbySupplyGood;
   logic powerStatusSidebandIn, externalThermalSensorN, managerDriveLow;
   logic extHot, mgrExtLow, raiseAlert;
   logic powerStatusSidebandOut, managerLineLevel, vrBusy, vrAlert, thermalControlActive;
   logic haltExecution, operationEnable, openLoopThermalMgmt, closedLoopThermalMgmt;
   etps_pkg::etps_od_t     catastrophic_error_n, hotPin, tripPin, vrClk, vrData, mgrPin;
   etps_pkg::etps_vr_req_t vrReq;
   etps_pkg::etps_vr_rsp_t vrRsp;
   wire logic              modelLow, alertN;
   int                     error_cnt, cmp_count, seed, len, i;

   // open-drain lines with pull-ups, any party may pull low
   wire logic hotLine  = ~(hotPin.oe | extHot);
   wire logic clkLine  = ~vrClk.oe;
   wire logic dataLine = ~(vrData.oe | modelLow);
   wire logic mgrLine  = ~(mgrPin.oe | mgrExtLow);

   etps_signalling uut (.clock(clock), .reset_n(reset_n),
      .machineCheckFault(machineCheckFault), .internalFault(internalFault),
      .warmReset(warmReset), .coldReset(coldReset), .tempMaxSafe(tempMaxSafe),
      .tccEnable(tccEnable), .junctionOverTrip(junctionOverTrip),
      .catastrophicErrorN(catastrophic_error_n), .overtempAlertNIn(hotLine), .overtempAlertN(hotPin),
      .thermalShutdownN(tripPin), .coreSupplyGood(coreSupplyGood),
      .standbySupplyGood(standbySupplyGood), .regulatorSerialClock(vrClk),
      .regulatorSerialDataIn(dataLine), .regulatorSerialData(vrData),
      .regulatorAlertN(alertN), .powerStatusSidebandIn(powerStatusSidebandIn),
      .powerStatusSidebandOut(powerStatusSidebandOut),
      .externalThermalSensorN(externalThermalSensorN), .managerLineIn(mgrLine),
      .managerLine(mgrPin), .managerDriveLow(managerDriveLow),
      .managerLineLevel(managerLineLevel), .vrReq(vrReq), .vrRsp(vrRsp), .vrBusy(vrBusy),
      .vrAlert(vrAlert), .thermalControlActive(thermalControlActive),
      .openLoopThermalMgmt(openLoopThermalMgmt),
      .closedLoopThermalMgmt(closedLoopThermalMgmt),
      .haltExecution(haltExecution), .operationEnable(operationEnable));

   etps_regulator_model partner (.reset_n(reset_n), .sclkLine(clkLine), .dataLine(dataLine),
      .raiseAlert(raiseAlert), .dataDriveLow(modelLow), .alertN(alertN));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // expected regulator answer for a command
   function automatic logic [7:0] expRsp(input logic [7:0] cmd);
      return {cmd[3:0], cmd[7:4]} ^ 8'h3C;
   endfunction

   // cycles the catastrophic pin stays driven
   task automatic measureCat(output int n);
      n = 0;
      while (catastrophic_error_n.oe === 1'b1 && n < 100)
      begin
         n++;
         tick(1);
      end
   endtask

   // one regulator frame, optionally poked while busy
   task automatic vrFrame(input logic [7:0] cmd, input bit poke);
      int n;
      vrReq = '{1'b1, cmd};
      tick(1);
      vrReq.start = 1'b0;
      chk("busy", vrBusy, 1);
      if (poke)
      begin
         tick(20);
         vrReq = '{1'b1, ~cmd};
         tick(1);
         vrReq.start = 1'b0;
      end
      n = 0;
      while (vrRsp.done !== 1'b1 && n < 300)
      begin
         n++;
         tick(1);
      end
      if (n >= 300)
      begin
         error_cnt++;
         $display("CHECK FAILED frame done expected 1 seen timeout");
         summarize();
      end
      chk("frame answer", vrRsp.rsp, expRsp(cmd));
      tick(1);
      chk("done pulse", vrRsp.done, 0);
      chk("link clock idle", clkLine, 1);
   endtask

   // ------------------------------------------------------------
   // clock, watchdog
   // ------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial
   begin
      repeat (50000) @(posedge clock);
      error_cnt++;
      $display("CHECK FAILED run length expected end seen timeout");
      summarize();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {machineCheckFault, internalFault, warmReset, coldReset, tempMaxSafe} = '0;
      {junctionOverTrip, powerStatusSidebandIn, managerDriveLow, extHot} = '0;
      {mgrExtLow, raiseAlert} = '0;
      {tccEnable, externalThermalSensorN} = 2'b11;
      {coreSupplyGood, standbySupplyGood} = 2'b00;
      vrReq = '0;
      error_cnt = 0;
      cmp_count = 0;
      seed = 80;
      reset_n = 1'b0;
      tick(4);
      chk("pins released in reset", {catastrophic_error_n.oe, tripPin.oe, hotPin.oe, vrClk.oe}, 0);
      reset_n = 1'b1;
      tick(2);
      {coreSupplyGood, standbySupplyGood} = 2'b11;
      tick(4);
      // machine check pulse, then a reload in mid-pulse
      for (i = 0; i < 2; i++)
      begin
         machineCheckFault = 1'b1;
         tick(1);
         machineCheckFault = 1'b0;
         if (i == 1)
         begin
            tick(9);
            machineCheckFault = 1'b1;
            tick(1);
            machineCheckFault = 1'b0;
         end
         chk("pin driven low", catastrophic_error_n.out, 0);
         measureCat(len);
         chk("machine check pulse", len[15:0], 16);
         tick(3);
      end
      // internal fault latch cleared by warm, then cold reset
      for (i = 0; i < 2; i++)
      begin
         internalFault = 1'b1;
         warmReset = (i == 0);
         tick(1);
         {internalFault, warmReset} = 2'b00;
         tick(40);
         chk("internal fault held", catastrophic_error_n.oe, 1);
         if (i == 0)
            warmReset = 1'b1;
         else
            coldReset = 1'b1;
         tick(1);
         {warmReset, coldReset} = 2'b00;
         tick(1);
         chk("internal fault cleared", catastrophic_error_n.oe, 0);
      end
      // random thermal and sideband traffic, no fault raised
      for (i = 0; i < 80; i++)
      begin
         chk("overtemp follows monitor", hotPin.oe, tempMaxSafe);
         chk("no spurious error", catastrophic_error_n.oe, 0);
         chk("manager drive", mgrPin.oe, managerDriveLow);
         {tempMaxSafe, tccEnable, powerStatusSidebandIn} = 3'($random(seed));
         {externalThermalSensorN, managerDriveLow, raiseAlert} = 3'($random(seed));
         tick(1);
      end
      {tempMaxSafe, managerDriveLow, raiseAlert} = 3'b000;
      {powerStatusSidebandIn, externalThermalSensorN} = 2'b01;
      tccEnable = 1'b1;
      tick(5);
      tempMaxSafe = 1'b1;
      tick(2);
      chk("control active when enabled", thermalControlActive, 1);
      tccEnable = 1'b0;
      tick(2);
      chk("control idle when disabled", thermalControlActive, 0);
      tempMaxSafe = 1'b0;
      for (i = 0; i < 5; i++)
      begin
         tick(1);
         chk("no self forced hot", thermalControlActive, 0);
      end
      extHot = 1'b1;
      tick(4);
      chk("forced hot", thermalControlActive, 1);
      extHot = 1'b0;
      tick(4);
      chk("forced hot ends", thermalControlActive, 0);
      externalThermalSensorN = 1'b0;
      tick(4);
      chk("wake sideband", powerStatusSidebandOut, 1);
      chk("open loop wake", openLoopThermalMgmt, 1);
      chk("closed loop wake", closedLoopThermalMgmt, 1);
      externalThermalSensorN = 1'b1;
      tick(4);
      chk("wake sideband ends", powerStatusSidebandOut, 0);
      chk("open loop idle", openLoopThermalMgmt, 0);
      chk("closed loop idle", closedLoopThermalMgmt, 0);
      powerStatusSidebandIn = 1'b1;
      tick(3);
      chk("hub status folded", closedLoopThermalMgmt, 1);
      chk("hub status not open loop", openLoopThermalMgmt, 0);
      powerStatusSidebandIn = 1'b0;
      mgrExtLow = 1'b1;
      tick(3);
      chk("manager level low", managerLineLevel, 0);
      mgrExtLow = 1'b0;
      managerDriveLow = 1'b1;
      tick(3);
      chk("manager self drive", managerLineLevel, 0);
      managerDriveLow = 1'b0;
      raiseAlert = 1'b1;
      tick(3);
      chk("regulator alert", vrAlert, 1);
      raiseAlert = 1'b0;
      tick(3);
      chk("regulator alert ends", vrAlert, 0);
      coreSupplyGood = 1'b0;
      tick(3);
      chk("core good gates", operationEnable, 0);
      coreSupplyGood = 1'b1;
      standbySupplyGood = 1'b0;
      tick(3);
      chk("standby good gates", operationEnable, 0);
      standbySupplyGood = 1'b1;
      tick(3);
      chk("operation enabled", operationEnable, 1);
      // regulator frames: corners, a refused start, random commands
      vrFrame(8'h00, 1'b0);
      vrFrame(8'hFF, 1'b1);
      for (i = 0; i < 6; i++)
         vrFrame(8'($random(seed)), 1'b0);
      // junction trip is sticky until reset, reset in mid-pulse
      junctionOverTrip = 1'b1;
      machineCheckFault = 1'b1;
      tick(1);
      {junctionOverTrip, machineCheckFault} = 2'b00;
      tick(5);
      chk("halt and trip", {haltExecution, tripPin.oe, operationEnable}, 3'b110);
      reset_n = 1'b0;
      tick(2);
      chk("released by reset", {tripPin.oe, catastrophic_error_n.oe, haltExecution}, 0);
      reset_n = 1'b1;
      tick(3);
      vrFrame(8'hA5, 1'b0);
      summarize();
   end
endmodule

`default_nettype wire
